// ### design/gpd_pkg.sv
// Purpose: Shared constants and types for the port D control block
// Assumes: One clock, one synchronous active-low reset
// Notes: Byte offsets are those of the register window
`default_nettype none
package gpd_pkg;
  localparam int GPD_PINS = 8;
  localparam logic [5:0] GPD_OFF_DATA = 6'h00;
  localparam logic [5:0] GPD_OFF_OE = 6'h04;
  localparam logic [5:0] GPD_OFF_FUNC = 6'h10;
  localparam logic [5:0] GPD_OFF_OD = 6'h28;
  localparam logic [5:0] GPD_OFF_PU = 6'h2C;
  localparam logic [5:0] GPD_OFF_IE = 6'h38;
  localparam logic [7:0] GPD_RST_VAL = 8'h00;
  localparam logic [7:0] GPD_FUNC_MASK = 8'h8F;
  localparam logic [1:0] GPD_RESP_OKAY = 2'h0;
  localparam logic [1:0] GPD_RESP_SLVERR = 2'h2;
  localparam int GPD_BIT_CLKOUT = 7;
  localparam int GPD_BIT_TRIG = 3;
  typedef enum logic [2:0] {
    GPD_W_IDLE = 3'b001,
    GPD_W_RESP = 3'b010,
    GPD_W_HOLD = 3'b100
  } gpd_wstate_t;
endpackage : gpd_pkg
`default_nettype wire

// ### design/gpd_cfg_if.sv
// Purpose: Carries per-pin configuration from the register bank to the pin logic
// Assumes: All signals in the aclk domain
// Notes: One bit per pin
`default_nettype none
interface gpd_cfg_if;
  logic [7:0] data;
  logic [7:0] oe;
  logic [7:0] func;
  logic [7:0] od;
  logic [7:0] pu;
  logic [7:0] ie;
  logic [7:0] alt_out;
  logic [7:0] pin_in;
  logic stop_mode;
  logic [7:0] read_level;
  logic [7:0] pad_out;
  logic [7:0] pad_oe;
  logic [7:0] pad_pu;
  logic [7:0] ext_int;
  logic adc_trig;
  modport regs (output data, oe, func, od, pu, ie, alt_out, pin_in, stop_mode,
    input read_level, pad_out, pad_oe, pad_pu, ext_int, adc_trig);
  modport pins (input data, oe, func, od, pu, ie, alt_out, pin_in, stop_mode,
    output read_level, pad_out, pad_oe, pad_pu, ext_int, adc_trig);
endinterface : gpd_cfg_if
`default_nettype wire

// ### design/gpd_pin_mux.sv
// Purpose: Per-pin output drive, open-drain, pull-up and input gating
// Assumes: Pin levels arrive synchronous to the clock
// Notes: Purely combinational; the top registers every pad signal
`default_nettype none
module gpd_pin_mux
  import gpd_pkg::*;
(
  gpd_cfg_if.pins cfg
);
  genvar i;
  for (i = 0; i < GPD_PINS; i++) begin : g_pin
    wire logic use_alt;
    wire logic drv_val;
    assign use_alt = cfg.func[i];
    assign drv_val = use_alt ? cfg.alt_out[i] : cfg.data[i];
    // Open drain drives only a low level
    assign cfg.pad_out[i] = cfg.od[i] ? 1'b0 : drv_val;
    assign cfg.pad_oe[i] = cfg.oe[i] & (cfg.od[i] ? ~drv_val : 1'b1);
    assign cfg.pad_pu[i] = cfg.pu[i];
    assign cfg.read_level[i] = cfg.ie[i] & cfg.pin_in[i];
    assign cfg.ext_int[i] = cfg.ie[i] & ~cfg.stop_mode & cfg.pin_in[i];
  end
  assign cfg.adc_trig = cfg.func[GPD_BIT_TRIG] & cfg.ie[GPD_BIT_TRIG]
    & cfg.pin_in[GPD_BIT_TRIG];
endmodule : gpd_pin_mux
`default_nettype wire

// ### design/gpd_regs.sv
// Purpose: Register storage for the six port registers
// Assumes: Write strobes are one-cycle pulses from the bus slave
// Notes: Function register keeps only its implemented bits
`default_nettype none
module gpd_regs
  import gpd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] we,
  input wire logic [7:0] wdata,
  output logic [7:0] data_q,
  output logic [7:0] oe_q,
  output logic [7:0] func_q,
  output logic [7:0] od_q,
  output logic [7:0] pu_q,
  output logic [7:0] ie_q
);
  wire logic [7:0] store [6];
  genvar r;
  for (r = 0; r < 6; r++) begin : g_reg
    wire logic [7:0] mask;
    logic [7:0] val_q;
    assign mask = (r == 2) ? GPD_FUNC_MASK : 8'hFF;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        val_q <= GPD_RST_VAL;
      end else if (we[r]) begin
        val_q <= wdata & mask;
      end
    end
    assign store[r] = val_q;
  end
  assign data_q = store[0];
  assign oe_q = store[1];
  assign func_q = store[2];
  assign od_q = store[3];
  assign pu_q = store[4];
  assign ie_q = store[5];
endmodule : gpd_regs
`default_nettype wire

// ### design/gpd_port.sv
// Purpose: Eight-pin general purpose port with AXI4-Lite register access
// Assumes: Pins and peripheral signals synchronous to aclk
// Notes: Reserved slots answer SLVERR, read data zero
// Operation
// - The data register holds eight pin bits in the low byte, reset zero, upper bits read zero.
// - The output control register has one enable per pin, one drives, reset zero.
// - The function register picks port or alternate use per bit; bits 6 to 4 read zero.
// - The open-drain register picks push-pull at zero and open-drain at one, reset zero.
// - The pull-up register enables each pin pull-up at one, reset zero.
// - The input control register enables each pin input at one, reset zero.
// - Outside deep stop a pin interrupt input is live whenever its input is enabled.
// - After reset every pin is a plain port pin with input, output and pull-up off.
// - Registers sit at offsets 0x00, 0x04, 0x10, 0x28, 0x2C and 0x38; others are reserved.
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`default_nettype none
module gpd_port
  import gpd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup,
  input wire logic timer_a_output,
  input wire logic timer_b_output,
  input wire logic timer_c_output,
  input wire logic system_clock_output,
  input wire logic stop_mode,
  output logic [7:0] ext_int,
  output logic converter_trigger_input
);
  gpd_cfg_if cfg ();
  gpd_wstate_t wstate_q;
  gpd_wstate_t wstate_d;
  logic [5:0] awaddr_q;
  logic aw_got_q;
  logic [7:0] wdata_q;
  logic w_got_q;
  logic wstrb_q;
  logic awready_q;
  logic wready_q;
  logic arready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] pin_out_q;
  logic [7:0] pin_oe_q;
  logic [7:0] pin_pu_q;
  logic [7:0] ext_int_q;
  logic trig_q;
  logic [7:0] data_q;
  logic [7:0] oe_q;
  logic [7:0] func_q;
  logic [7:0] od_q;
  logic [7:0] pu_q;
  logic [7:0] ie_q;

  // Address and data may arrive in either order; each half is held until the other comes
  wire logic wr_idle;
  wire logic aw_take;
  wire logic w_take;
  wire logic both_in;
  wire logic aw_held_d;
  wire logic w_held_d;
  wire logic awready_d;
  wire logic wready_d;
  wire logic [5:0] wr_addr;
  wire logic [7:0] w_byte;
  wire logic w_strb;
  wire logic [7:0] wr_byte;
  assign wr_idle = (wstate_q == GPD_W_IDLE);
  assign aw_take = s_axi_awvalid & awready_q;
  assign w_take = s_axi_wvalid & wready_q;
  assign both_in = (aw_got_q | aw_take) & (w_got_q | w_take) & wr_idle;
  assign aw_held_d = (aw_got_q | aw_take) & ~both_in;
  assign w_held_d = (w_got_q | w_take) & ~both_in;
  // Ready rises the cycle after valid and falls with the handshake, so it is a flop
  assign awready_d = s_axi_awvalid & ~aw_take & ~aw_held_d & (wstate_d == GPD_W_IDLE);
  assign wready_d = s_axi_wvalid & ~w_take & ~w_held_d & (wstate_d == GPD_W_IDLE);
  assign wr_addr = aw_take ? s_axi_awaddr : awaddr_q;
  assign w_byte = w_take ? s_axi_wdata[7:0] : wdata_q;
  assign w_strb = w_take ? s_axi_wstrb[0] : wstrb_q;
  // Merge with the stored byte only once the address is known
  assign wr_byte = w_strb ? w_byte : data_sel(wr_addr);

  // Decode of the six implemented slots
  wire logic [5:0] wr_hit;
  wire logic wr_ok;
  wire logic [5:0] we;
  assign wr_hit[0] = (wr_addr[5:2] == GPD_OFF_DATA[5:2]);
  assign wr_hit[1] = (wr_addr[5:2] == GPD_OFF_OE[5:2]);
  assign wr_hit[2] = (wr_addr[5:2] == GPD_OFF_FUNC[5:2]);
  assign wr_hit[3] = (wr_addr[5:2] == GPD_OFF_OD[5:2]);
  assign wr_hit[4] = (wr_addr[5:2] == GPD_OFF_PU[5:2]);
  assign wr_hit[5] = (wr_addr[5:2] == GPD_OFF_IE[5:2]);
  assign wr_ok = |wr_hit;
  assign we = both_in ? wr_hit : 6'h00;

  function automatic logic [7:0] data_sel(input logic [5:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a[5:2])
      GPD_OFF_DATA[5:2]: v = data_q;
      GPD_OFF_OE[5:2]: v = oe_q;
      GPD_OFF_FUNC[5:2]: v = func_q;
      GPD_OFF_OD[5:2]: v = od_q;
      GPD_OFF_PU[5:2]: v = pu_q;
      GPD_OFF_IE[5:2]: v = ie_q;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : data_sel

  always_comb begin
    wstate_d = wstate_q;
    case (wstate_q)
      GPD_W_IDLE: begin
        if (both_in) begin
          wstate_d = GPD_W_RESP;
        end
      end
      GPD_W_RESP: begin
        if (s_axi_bready) begin
          wstate_d = GPD_W_IDLE;
        end else begin
          wstate_d = GPD_W_HOLD;
        end
      end
      GPD_W_HOLD: begin
        if (s_axi_bready) begin
          wstate_d = GPD_W_IDLE;
        end
      end
      default: wstate_d = GPD_W_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate_q <= GPD_W_IDLE;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
    end else begin
      wstate_q <= wstate_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      awaddr_q <= 6'h00;
    end else begin
      aw_got_q <= aw_held_d;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
    end
  end

  // The raw byte and its strobe wait here when data comes before the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_q <= 1'b0;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
    end else begin
      w_got_q <= w_held_d;
      if (w_take) begin
        wdata_q <= s_axi_wdata[7:0];
        wstrb_q <= s_axi_wstrb[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= GPD_RESP_OKAY;
    end else if (both_in) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? GPD_RESP_OKAY : GPD_RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read channel: one read at a time, answered the cycle after acceptance
  wire logic ar_take;
  wire logic arready_d;
  wire logic rd_ok;
  wire logic [7:0] rd_byte;
  assign ar_take = s_axi_arvalid & arready_q;
  // A new read is offered ready only once the previous answer is gone
  assign arready_d = s_axi_arvalid & ~ar_take & (~rvalid_q | s_axi_rready);
  assign rd_ok = (s_axi_araddr[5:2] == GPD_OFF_DATA[5:2])
    | (s_axi_araddr[5:2] == GPD_OFF_OE[5:2])
    | (s_axi_araddr[5:2] == GPD_OFF_FUNC[5:2])
    | (s_axi_araddr[5:2] == GPD_OFF_OD[5:2])
    | (s_axi_araddr[5:2] == GPD_OFF_PU[5:2])
    | (s_axi_araddr[5:2] == GPD_OFF_IE[5:2]);
  // Data reads show gated pin levels, not the stored output value
  assign rd_byte = (s_axi_araddr[5:2] == GPD_OFF_DATA[5:2]) ? cfg.read_level
    : data_sel(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= GPD_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= rd_ok ? GPD_RESP_OKAY : GPD_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
    end else begin
      arready_q <= arready_d;
    end
  end

  gpd_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(we),
    .wdata(wr_byte),
    .data_q(data_q),
    .oe_q(oe_q),
    .func_q(func_q),
    .od_q(od_q),
    .pu_q(pu_q),
    .ie_q(ie_q)
  );

  assign cfg.data = data_q;
  assign cfg.oe = oe_q;
  assign cfg.func = func_q;
  assign cfg.od = od_q;
  assign cfg.pu = pu_q;
  assign cfg.ie = ie_q;
  assign cfg.pin_in = pin_in;
  assign cfg.stop_mode = stop_mode;
  assign cfg.alt_out = {system_clock_output, 3'b000, 1'b0, timer_c_output,
    timer_b_output, timer_a_output};

  gpd_pin_mux u_mux (
    .cfg(cfg)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_q <= 8'h00;
      pin_oe_q <= 8'h00;
      pin_pu_q <= 8'h00;
      ext_int_q <= 8'h00;
      trig_q <= 1'b0;
    end else begin
      pin_out_q <= cfg.pad_out;
      pin_oe_q <= cfg.pad_oe;
      pin_pu_q <= cfg.pad_pu;
      ext_int_q <= cfg.ext_int;
      trig_q <= cfg.adc_trig;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  assign pin_pullup = pin_pu_q;
  assign ext_int = ext_int_q;
  assign converter_trigger_input = trig_q;
endmodule : gpd_port
`default_nettype wire

// ### dv/gpd_port_monitor.sv
// Purpose: Concurrent checks on the port D control block ports
// Assumes: The master offers write address and data in the same cycle
// Notes: Bound to every gpd_port instance
`default_nettype none
module gpd_port_monitor
  import gpd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic stop_mode,
  input wire logic [7:0] ext_int,
  input wire logic converter_trigger_input
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire logic aw_rsv = !(s_axi_awaddr inside {GPD_OFF_DATA, GPD_OFF_OE, GPD_OFF_FUNC,
    GPD_OFF_OD, GPD_OFF_PU, GPD_OFF_IE});
  wire logic ar_rsv = !(s_axi_araddr inside {GPD_OFF_DATA, GPD_OFF_OE, GPD_OFF_FUNC,
    GPD_OFF_OD, GPD_OFF_PU, GPD_OFF_IE});
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_RESP: assert property (wr_take |=> s_axi_bvalid &&
    s_axi_bresp == ($past(aw_rsv) ? GPD_RESP_SLVERR : GPD_RESP_OKAY)) else $error("bad bresp");
  AST_RD_RESP: assert property (rd_take |=> s_axi_rvalid &&
    s_axi_rresp == ($past(ar_rsv) ? GPD_RESP_SLVERR : GPD_RESP_OKAY)) else $error("bad rresp");
  AST_RD_RSV_ZERO: assert property (rd_take ##0 ar_rsv |=> s_axi_rdata == 32'h0)
    else $error("reserved read data not zero");
  AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_FUNC_RD: assert property (rd_take ##0 s_axi_araddr == GPD_OFF_FUNC |=>
    s_axi_rdata[6:4] == 3'h0) else $error("function bits 6 to 4 not zero");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  AST_STOP_INT: assert property (stop_mode |=> ext_int == 8'h00)
    else $error("interrupt input live in stop");
  AST_INT_PIN: assert property ((ext_int & ~$past(pin_in)) == 8'h00)
    else $error("interrupt without pin level");
  AST_TRIG: assert property (converter_trigger_input |-> $past(pin_in[3]))
    else $error("trigger without pin level");
  AST_RST: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=>
    pin_oe == 8'h00 && pin_pullup == 8'h00 && ext_int == 8'h00) else $error("reset state");
endmodule : gpd_port_monitor
bind gpd_port gpd_port_monitor u_mon (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .pin_in, .pin_oe, .pin_pullup, .stop_mode, .ext_int, .converter_trigger_input);
`default_nettype wire

// ### dv/gpd_pin_model.sv
// Purpose: Pads and outside world of the eight port pins
// Assumes: Outside driver only where the bench enables it
// Notes: An undriven pad without pull-up wanders every cycle
`default_nettype none
module gpd_pin_model (
  input wire logic aclk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] ext_drv,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] flt_q = 8'h55;
  always @(posedge aclk) flt_q <= ~flt_q;
  // Own drive wins, then the outside driver, then pull-up or a floating level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_drv) |
    (~pin_oe & ~ext_en & (pin_pullup | flt_q));
endmodule : gpd_pin_model
`default_nettype wire

// ### dv/gpd_port_tb_top.sv
// Purpose: Self-checking bench for the port D control block
// Assumes: Seeded random stimulus, pins modelled by gpd_pin_model
// Notes: Pin checks wait three edges after the last register write
`default_nettype none
module gpd_port_tb_top
  import gpd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic awrdy, wrdy, bv, arrdy, rv, trig, stop = 1'b0;
  logic [5:0] awa = 6'h00, ara = 6'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0] bresp, rresp;
  logic [3:0] alt = 4'h0;
  logic [7:0] ext_drv = 8'h00, ext_en = 8'h00, pin_in, p_out, p_oe, p_pu, eint;
  logic [5:0] offs [5] = '{GPD_OFF_OE, GPD_OFF_FUNC, GPD_OFF_OD, GPD_OFF_PU, GPD_OFF_IE};
  int n_errors = 0, total_checks = 0, cyc = 0, seed = 43;
  gpd_port dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arrdy), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .pin_in(pin_in),
    .pin_out(p_out), .pin_oe(p_oe), .pin_pullup(p_pu), .timer_a_output(alt[0]),
    .timer_b_output(alt[1]), .timer_c_output(alt[2]), .system_clock_output(alt[3]),
    .stop_mode(stop), .ext_int(eint), .converter_trigger_input(trig));
  gpd_pin_model u_pins (.aclk(aclk), .pin_out(p_out), .pin_oe(p_oe), .pin_pullup(p_pu),
    .ext_drv(ext_drv), .ext_en(ext_en), .pin_in(pin_in));
  initial begin
    forever #4 aclk = ~aclk;
  end
  function automatic logic [7:0] pad_oe(logic [7:0] oe, logic [7:0] od, logic [7:0] dat);
    return oe & ~(od & dat);
  endfunction : pad_oe
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk({24'h0, got}, {24'h0, exp});
  endtask : chk8
  task automatic axw(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, ad, wdn;
    ad = 1'b0;
    wdn = 1'b0;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!ad || !wdn) begin
      @(negedge aclk);
      ah = awv & awrdy;
      wh = wv & wrdy;
      ad |= ah;
      wdn |= wh;
      @(posedge aclk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
    end
    do @(negedge aclk); while (bv !== 1'b1);
    r = bresp;
    @(posedge aclk);
    br <= 1'b0;
  endtask : axw
  task automatic axr(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(negedge aclk); while (arrdy !== 1'b1);
    @(posedge aclk);
    arv <= 1'b0;
    do @(negedge aclk); while (rv !== 1'b1);
    d = rdat;
    r = rresp;
    @(posedge aclk);
    rr <= 1'b0;
  endtask : axr
  task automatic acc(input logic [5:0] a, input logic [31:0] d, input logic [31:0] e,
    input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] r;
    axw(a, d, r);
    chk8({6'h00, r}, {6'h00, er});
    axr(a, q, r);
    chk8({6'h00, r}, {6'h00, er});
    chk(q, e);
  endtask : acc
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk8({6'h00, r}, {6'h00, GPD_RESP_OKAY});
  endtask : wr
  initial begin
    logic [5:0] a;
    logic [31:0] v, rq;
    logic [1:0] r;
    int k;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk8(p_oe | p_pu | eint | p_out, 8'h00);
    for (int s = 0; s < 16; s++) begin
      a = 6'(s * 4);
      if (!(a inside {GPD_OFF_DATA, offs})) acc(a, $random(seed), 32'h0, GPD_RESP_SLVERR);
    end
    axr(GPD_OFF_DATA, rq, r);
    chk(rq, 32'h0);
    for (int i = 0; i < 5; i++) begin
      axr(offs[i], rq, r);
      chk(rq, 32'h0);
    end
    $display("test reset and reserved done");
    for (int i = 0; i < 30; i++) begin
      k = {$random(seed)} % 5;
      v = $random(seed);
      acc(offs[k], v, {24'h0, v[7:0] & (k == 1 ? GPD_FUNC_MASK : 8'hFF)},
        GPD_RESP_OKAY);
    end
    $display("test register access done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      axr(offs[i], rq, r);
      chk(rq, 32'h0);
    end
    acc(GPD_OFF_FUNC, 32'h0, 32'h0, GPD_RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      wr(GPD_OFF_OE, {24'h0, v[7:0]});
      wr(GPD_OFF_OD, {24'h0, v[15:8]});
      wr(GPD_OFF_DATA, {24'h0, v[23:16]});
      wr(GPD_OFF_PU, {24'h0, v[31:24]});
      wr(GPD_OFF_IE, {24'h0, ~v[7:0]});
      ext_drv <= 8'($random(seed));
      ext_en <= 8'hFF;
      stop <= v[8];
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk8(p_oe, pad_oe(v[7:0], v[15:8], v[23:16]));
      chk8(p_out & p_oe, v[7:0] & ~v[15:8] & v[23:16]);
      chk8(p_pu, v[31:24]);
      chk8(eint, stop ? 8'h00 : ~v[7:0] & ext_drv);
      axr(GPD_OFF_DATA, rq, r);
      chk(rq, {24'h0, ~v[7:0] & ext_drv});
    end
    $display("test pin drive and input done");
    wr(GPD_OFF_OD, 32'h0);
    wr(GPD_OFF_OE, 32'hF7);
    wr(GPD_OFF_IE, 32'h08);
    wr(GPD_OFF_FUNC, 32'hFF);
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      alt <= 4'($random(seed));
      ext_drv <= 8'($random(seed));
      stop <= 1'b0;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk8(p_out & 8'h87, {alt[3], 4'h0, alt[2:0]});
      chk8({7'h00, trig}, {7'h00, ext_drv[3]});
      chk8(eint, 8'h08 & ext_drv);
    end
    $display("test alternate functions done");
    final_report();
  end
endmodule : gpd_port_tb_top
`default_nettype wire
